/* logic/fwsp_ctrl.sv */
// flash write status polling controller with an AXI4-Lite register slave
// assumes the flash status bits on the data lines and a pulled-up ready/busy line
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "fwsp_params.svh"
module fwsp_ctrl
  import fwsp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output fwsp_addr_t flashAddr,
  output fwsp_word_t flashDqOut,
  output logic flashDqOe,
  input wire fwsp_word_t flashDqIn,
  input wire logic ready_busy_n
);
  typedef enum logic [2:0] {FWSP_IDLE, FWSP_WRITE, FWSP_RD1, FWSP_RD2, FWSP_RD3, FWSP_RDARR, FWSP_RST} fwsp_state_e;
  fwsp_state_e state, next_state;
  fwsp_addr_t addrReg;
  fwsp_word_t dataReg;
  logic [4:0] ctrlReg;
  fwsp_result_e result;
  fwsp_word_t firstRead, lastRead, arrayData;
  logic cycStart, cycWrite, cycDone;
  fwsp_word_t cycRead;
  fwsp_addr_t cycAddr;
  fwsp_word_t cycData;
  logic flashBusySeen;
  logic [7:0] awAddr;
  logic awHeld, wHeld;
  logic [31:0] wData;
  logic wStrb0;
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire writeFire = awHeld && wHeld && !s_axi_bvalid;
  wire idle = (state == FWSP_IDLE);
  wire hitCtrl = (awAddr == `FWSP_OFF_CTRL);
  wire hitAddr = (awAddr == `FWSP_OFF_ADDR);
  wire hitData = (awAddr == `FWSP_OFF_DATA);
  wire writeOk = hitCtrl || hitAddr || hitData;
  wire goCmd = writeFire && hitCtrl && wStrb0 && wData[`FWSP_CTRL_GO] && idle;
  wire abandon = ctrlReg[`FWSP_CTRL_ABANDON];
  // toggle bit under test: toggle two only when the host asks for it
  wire [3:0] togBit = ctrlReg[`FWSP_CTRL_TB2] ? 4'(`FWSP_DQ_TOG2) : 4'(`FWSP_DQ_TOG1);
  wire toggled = (firstRead[togBit] != cycRead[togBit]);
  wire failBit = cycRead[`FWSP_DQ_FAIL];
  wire [31:0] statWord = {24'h000000, ready_busy_n, flashBusySeen, result, 1'b0,
                          !idle, lastRead[`FWSP_DQ_TIMER], lastRead[`FWSP_DQ_FAIL]};
  wire [7:0] rAddr = s_axi_araddr;
  wire rdHit = (rAddr == `FWSP_OFF_CTRL) || (rAddr == `FWSP_OFF_ADDR) || (rAddr == `FWSP_OFF_DATA)
               || (rAddr == `FWSP_OFF_STAT) || (rAddr == `FWSP_OFF_RDAT);
  wire [31:0] rdMux = (rAddr == `FWSP_OFF_CTRL) ? {27'h0000000, ctrlReg} :
                      (rAddr == `FWSP_OFF_ADDR) ? {12'h000, addrReg} :
                      (rAddr == `FWSP_OFF_DATA) ? {16'h0000, dataReg} :
                      (rAddr == `FWSP_OFF_STAT) ? statWord :
                      (rAddr == `FWSP_OFF_RDAT) ? {lastRead, arrayData} : 32'h00000000;
  assign cycAddr = addrReg;
  assign cycData = (state == FWSP_RST) ? `FWSP_RESET_CMD : dataReg;
  assign cycWrite = (state == FWSP_WRITE) || (state == FWSP_RST);
  // no start in the done cycle: the old state would relaunch its own cycle
  assign cycStart = !idle && !cycDone;

  fwsp_bus_cycle fwsp_bus_cycle_inst (
    .clk(clk),
    .reset(reset),
    .clkEn(clkEn),
    .start(cycStart),
    .isWrite(cycWrite),
    .addrIn(cycAddr),
    .dataIn(cycData),
    .done(cycDone),
    .readData(cycRead),
    .flashCeN(flashCeN),
    .flashOeN(flashOeN),
    .flashWeN(flashWeN),
    .flashAddr(flashAddr),
    .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe),
    .flashDqIn(flashDqIn)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      FWSP_IDLE:
        if (goCmd)
          next_state = wData[`FWSP_CTRL_WR] ? FWSP_WRITE : (wData[`FWSP_CTRL_POLL] ? FWSP_RD1 : FWSP_RDARR);
      FWSP_WRITE:
        if (cycDone)
          next_state = ctrlReg[`FWSP_CTRL_POLL] ? FWSP_RD1 : FWSP_IDLE;
      FWSP_RD1:
        if (cycDone)
          next_state = FWSP_RD2;
      FWSP_RD2:
        if (cycDone)
        begin
          if (!toggled)
            next_state = FWSP_RDARR;
          else if (failBit)
            next_state = FWSP_RD3;
          else if (abandon)
            next_state = FWSP_IDLE;
          else
            next_state = FWSP_RD2;
        end
      FWSP_RD3:
        if (cycDone)
          next_state = toggled ? FWSP_RST : FWSP_RDARR;
      FWSP_RDARR:
        if (cycDone)
          next_state = FWSP_IDLE;
      FWSP_RST:
        if (cycDone)
          next_state = FWSP_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state <= FWSP_IDLE;
    else if (clkEn)
      state <= next_state;
  end

  // status capture; compare always against the previous read so polling can continue
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      firstRead <= 16'h0000;
      lastRead <= 16'h0000;
      arrayData <= 16'h0000;
      result <= FWSP_RES_NONE;
      flashBusySeen <= 1'b0;
    end
    else if (clkEn)
    begin
      if (goCmd)
      begin
        result <= FWSP_RES_NONE;
        flashBusySeen <= 1'b0;
      end
      else if (!ready_busy_n && !idle)
        flashBusySeen <= 1'b1;
      if (cycDone && !cycWrite)
      begin
        firstRead <= cycRead;
        lastRead <= cycRead;
      end
      if (cycDone && state == FWSP_RDARR)
      begin
        arrayData <= cycRead;
        if (result == FWSP_RES_NONE)
          result <= FWSP_RES_PASS;
      end
      if (cycDone && state == FWSP_RD3 && toggled)
        result <= FWSP_RES_FAIL;
      if (cycDone && state == FWSP_RD2 && toggled && !failBit && abandon)
        result <= FWSP_RES_LEFT;
    end
  end

  // register slave: address and data in either order, one write and one read in flight
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h00000000;
      wStrb0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
      ctrlReg <= 5'h00;
      addrReg <= 20'h00000;
      dataReg <= 16'h0000;
    end
    else if (clkEn)
    begin
      if (awTake)
      begin
        awAddr <= s_axi_awaddr;
        awHeld <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (wTake)
      begin
        wData <= s_axi_wdata;
        wStrb0 <= s_axi_wstrb[0];
        wHeld <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (writeFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= writeOk ? 2'h0 : 2'h2;
        if (hitCtrl && wStrb0)
          ctrlReg <= {wData[4:1], 1'b0};
        if (hitAddr && idle)
          addrReg <= wData[19:0];
        if (hitData && idle)
          dataReg <= wData[15:0];
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (arTake)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

/* shared/fwsp_params.svh */
// timing counts and register offsets for the flash status polling controller
// assumes the 200 MHz system clock and a 32-bit register bus
`ifndef FWSP_PARAMS_SVH
`define FWSP_PARAMS_SVH
`define FWSP_CLK_MHZ 200
`define FWSP_ACC_NS 100
`define FWSP_ACC_CYC ((`FWSP_ACC_NS * `FWSP_CLK_MHZ + 999) / 1000)
`define FWSP_GAP_US 50
`define FWSP_GAP_CYC (`FWSP_GAP_US * `FWSP_CLK_MHZ)
`define FWSP_OFF_CTRL 8'h00
`define FWSP_OFF_ADDR 8'h04
`define FWSP_OFF_DATA 8'h08
`define FWSP_OFF_STAT 8'h0C
`define FWSP_OFF_RDAT 8'h10
`define FWSP_CTRL_GO 0
`define FWSP_CTRL_WR 1
`define FWSP_CTRL_POLL 2
`define FWSP_CTRL_TB2 3
`define FWSP_CTRL_ABANDON 4
`define FWSP_DQ_POLL 7
`define FWSP_DQ_TOG1 6
`define FWSP_DQ_FAIL 5
`define FWSP_DQ_TIMER 3
`define FWSP_DQ_TOG2 2
`define FWSP_RESET_CMD 16'h00F0
`endif

/* shared/fwsp_pkg.sv */
// types of the flash status polling controller
// used by both design files
package fwsp_pkg;
  typedef enum logic [1:0] {FWSP_RES_NONE, FWSP_RES_PASS, FWSP_RES_FAIL, FWSP_RES_LEFT} fwsp_result_e;
  typedef logic [15:0] fwsp_word_t;
  typedef logic [19:0] fwsp_addr_t;
endpackage

/* logic/fwsp_bus_cycle.sv */
// one asynchronous read or write cycle on the flash strobes
// assumes the flash access time fits the constant access count
`timescale 1ns/1ps
`include "fwsp_params.svh"
module fwsp_bus_cycle
  import fwsp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic start,
  input wire logic isWrite,
  input wire fwsp_addr_t addrIn,
  input wire fwsp_word_t dataIn,
  output logic done,
  output fwsp_word_t readData,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  output fwsp_addr_t flashAddr,
  output fwsp_word_t flashDqOut,
  output logic flashDqOe,
  input wire fwsp_word_t flashDqIn
);
  localparam logic [7:0] ACC = 8'(`FWSP_ACC_CYC);
  logic [7:0] cnt;
  logic busy;
  logic wr;
  wire lastCyc = busy && (cnt == ACC);
  wire strobeEnd = busy && (cnt == ACC + 8'h01);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy <= 1'b0;
      cnt <= 8'h00;
      wr <= 1'b0;
      done <= 1'b0;
      readData <= 16'h0000;
      flashCeN <= 1'b1;
      flashOeN <= 1'b1;
      flashWeN <= 1'b1;
      flashAddr <= 20'h00000;
      flashDqOut <= 16'h0000;
      flashDqOe <= 1'b0;
    end
    else if (clkEn)
    begin
      done <= strobeEnd;
      if (start && !busy)
      begin
        busy <= 1'b1;
        cnt <= 8'h00;
        wr <= isWrite;
        flashAddr <= addrIn;
        flashDqOut <= dataIn;
        flashDqOe <= isWrite;
        flashCeN <= 1'b0;
        flashOeN <= isWrite;
        flashWeN <= !isWrite;
      end
      else if (busy)
      begin
        cnt <= cnt + 8'h01;
        // capture on the same edge that raises the strobes, so data is sampled while still driven
        if (lastCyc && !wr)
          readData <= flashDqIn;
        if (lastCyc)
        begin
          flashCeN <= 1'b1;
          flashOeN <= 1'b1;
          flashWeN <= 1'b1;
        end
        if (strobeEnd)
        begin
          busy <= 1'b0;
          flashDqOe <= 1'b0;
        end
      end
    end
  end
endmodule

/* bench/fwsp_flash_model.sv */
// behavioural one-word flash answering program and status reads
// assumes the controller strobes change only on clk edges
`timescale 1ns/1ps
`include "fwsp_params.svh"
module fwsp_flash_model
  import fwsp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] busyReads,
  input wire logic flashCeN,
  input wire logic flashOeN,
  input wire logic flashWeN,
  input wire fwsp_word_t flashDqOut,
  output fwsp_word_t flashDqIn,
  output logic ready_busy_n
);
  fwsp_word_t mem, tgt, last, wdat;
  logic [7:0] left;
  logic tog, fail, rdD, wrD;
  wire logic rd = !flashOeN && !flashCeN;
  wire logic wr = !flashWeN && !flashCeN;
  wire logic busy = left != 8'h00 || fail;
  wire logic bad = (wdat & ~mem) != 16'h0000;
  wire fwsp_word_t st = {~tgt[15:7], tog, fail, ~tgt[4], 2'b00, ~tgt[1:0]};
  // array data once done; a released bus never repeats the old word
  assign flashDqIn = rd ? (busy ? st : mem) : ~last;
  assign ready_busy_n = !busy;
  always_ff @(posedge clk)
  begin
    rdD <= rd;
    wrD <= wr;
    if (rd)
      last <= flashDqIn;
    if (wr)
      wdat <= flashDqOut;
    if (reset)
    begin
      mem <= 16'hFFFF;
      left <= 8'h00;
      fail <= 1'b0;
      tog <= 1'b0;
      last <= 16'h0000;
    end
    else if (wrD && !wr && wdat == `FWSP_RESET_CMD)
    begin
      fail <= 1'b0;
      left <= 8'h00;
    end
    else if (wrD && !wr && !busy)
    begin
      tgt <= wdat;
      // a one over a zero never completes
      fail <= bad;
      left <= bad ? 8'h00 : busyReads;
      if (!bad)
        mem <= wdat;
    end
    // each new read while busy flips the toggle
    else if (rd && !rdD && busy)
    begin
      tog <= !tog;
      if (left != 8'h00)
        left <= left - 8'h01;
    end
  end
endmodule

/* bench/fwsp_ctrl_assertions.sv */
// bus and strobe assertions for the polling controller
// assumes clkEn stays high while bound
`timescale 1ns/1ps
`include "fwsp_params.svh"
module fwsp_ctrl_checker
(
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic flashCeN,
  input wire logic flashOeN,
  input wire logic flashWeN,
  input wire logic [19:0] flashAddr,
  input wire logic flashDqOe
);
  logic [7:0] lowCnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  always_ff @(posedge clk)
  begin
    lowCnt <= (reset || flashOeN) ? 8'h00 : lowCnt + 8'h01;
  end
  a_b_follows: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped");
  a_strobe_excl: assert property (!(!flashOeN && !flashWeN))
    else $error("read and write strobes together");
  a_write_drives: assert property (!flashWeN |-> flashDqOe && !flashCeN)
    else $error("write strobe without data drive");
  a_read_floats: assert property (!flashOeN |-> !flashDqOe && !flashCeN)
    else $error("read strobe while driving data");
  a_addr_hold: assert property (!flashCeN && $past(!flashCeN) |-> $stable(flashAddr))
    else $error("flash address moved in a cycle");
  a_read_long: assert property ($rose(flashOeN) |-> lowCnt >= `FWSP_ACC_CYC)
    else $error("read strobe shorter than access time");
  c_read: cover property ($rose(flashOeN));
  c_write: cover property ($rose(flashWeN));
  c_resp: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind fwsp_ctrl fwsp_ctrl_checker fwsp_ctrl_checker_inst (.clk(clk), .reset(reset),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
  .flashAddr(flashAddr), .flashDqOe(flashDqOe));

/* bench/fwsp_ctrl_tb.sv */
// random program and poll runs against the behavioural flash word
// assumes the register map of the controller hand-over
`timescale 1ns/1ps
`include "fwsp_params.svh"
module fwsp_ctrl_tb
  import fwsp_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, clkEn = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, busyReads = 8'h04;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h0B38, d;
  logic awready, wready, bvalid, arready, rvalid, ceN, oeN, weN, dqOe, rbN;
  logic [1:0] bresp, rresp, r;
  fwsp_addr_t fAddr;
  fwsp_word_t dqOut, dqIn, mem, w;
  int fail_count = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  fwsp_ctrl fwsp_ctrl_inst (.clk(clk), .reset(reset), .clkEn(clkEn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN), .flashAddr(fAddr), .flashDqOut(dqOut),
    .flashDqOe(dqOe), .flashDqIn(dqIn), .ready_busy_n(rbN));
  fwsp_flash_model fwsp_flash_model_inst (.clk(clk), .reset(reset), .busyReads(busyReads),
    .flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN), .flashDqOut(dqOut), .flashDqIn(dqIn),
    .ready_busy_n(rbN));
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
    end
  endfunction
  // failure whenever a one is asked over a zero
  function automatic logic [1:0] expRes(input fwsp_word_t m, input fwsp_word_t v);
    return ((v & ~m) != 16'h0000) ? 2'h2 : 2'h1;
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    begin
      checks_done++;
      if (s !== e)
      begin
        fail_count++;
        $display("ERROR %s expected %h seen %h", what, e, s);
      end
    end
  endtask
  task automatic summarize;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // an edge passes first so no strobe is driven twice in one step
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
        @(posedge clk);
        if (awready)
          awvalid <= 1'b0;
        if (wready)
          wvalid <= 1'b0;
      end
      while (!bvalid);
      bready <= 1'b0;
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
        @(posedge clk);
        if (arready)
          arvalid <= 1'b0;
        v = rdata;
        rr = rresp;
      end
      while (!rvalid);
      rready <= 1'b0;
    end
  endtask
  task automatic prog(input fwsp_word_t v, input logic [7:0] ctl, input logic [1:0] er);
    int n;
    begin
      seed = xs(seed);
      axw(`FWSP_OFF_ADDR, {12'h000, seed[19:0]});
      axw(`FWSP_OFF_DATA, {16'h0000, v});
      axw(`FWSP_OFF_CTRL, {24'h000000, ctl});
      n = 0;
      do
      begin
        axr(`FWSP_OFF_STAT, d, r);
        n++;
      end
      while (d[2] && n < 400);
      chk("poll_done", 32'h0, {31'h0, d[2]});
      chk("result", {30'h0, er}, {30'h0, d[5:4]});
      chk("fail_bit", {31'h0, (er == 2'h2) || (er == 2'h1 && v[5])}, {31'h0, d[0]});
      chk("timer_bit", {31'h0, er == 2'h1 && v[3]}, {31'h0, d[1]});
      chk("busy_seen", 32'h1, {31'h0, d[6]});
      chk("ready_line", {31'h0, er != 2'h3}, {31'h0, d[7]});
      if (er == 2'h1)
      begin
        axr(`FWSP_OFF_RDAT, d, r);
        chk("array_word", {v, v}, d);
      end
    end
  endtask
  initial
  begin
    #400000;
    fail_count++;
    summarize;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    axr(`FWSP_OFF_STAT, d, r);
    chk("stat_reset", 32'h00000080, d);
    axr(8'h20, d, r);
    chk("unmapped_resp", 32'h2, {30'h0, r});
    chk("unmapped_data", 32'h0, d);
    mem = 16'hFFFF;
    for (int i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      busyReads <= (i == 1) ? 8'h01 : 8'h03 + {5'h0, seed[2:0]};
      w = i[0] ? (mem & seed[31:16]) : seed[31:16];
      prog(w, 8'h07, expRes(mem, w));
      if (expRes(mem, w) == 2'h1)
        mem = w;
    end
    seed = xs(seed);
    w = mem & seed[31:16];
    busyReads <= 8'h01;
    prog(w, 8'h0F, 2'h1);
    mem = w;
    seed = xs(seed);
    w = mem & seed[15:0];
    busyReads <= 8'h28;
    prog(w, 8'h17, 2'h3);
    prog(w, 8'h05, 2'h1);
    summarize;
  end
endmodule
